// >>> rtc_flags_pkg.sv
// constants for the rtc control and status flag block
package rtc_flags_pkg;
    // register addresses
    localparam logic [3:0] CS_ONE_ADDR      = 4'h0;
    localparam logic [3:0] CS_TWO_ADDR      = 4'h1;
    // control_status_one field positions
    localparam int         OVR_TEST_POS     = 3;
    localparam int         DIV_HALT_POS     = 5;
    localparam int         EXTERNAL_CLOCK_TEST_MODE_POS      = 7;
    // control_status_two field positions
    localparam int         TIE_POS          = 0;
    localparam int         AIE_POS          = 1;
    localparam int         TF_POS           = 2;
    localparam int         AF_POS           = 3;
    localparam int         IRQ_MODE_POS     = 4;
    // reset values: only the reset-override test bit comes up set
    localparam logic [7:0] CS_ONE_RESET     = 8'h08;
    localparam logic [7:0] CS_TWO_RESET     = 8'h00;
    // divider width: 32.768 kHz down to 1 Hz
    localparam int         DIV_WIDTH        = 15;
    // timer pulse width in clk_in cycles
    localparam int         PULSE_TIME_NS    = 250;
    localparam int         CLK_PERIOD_NS    = 25;
    localparam int         PULSE_CYCLES     = PULSE_TIME_NS / CLK_PERIOD_NS;
    localparam logic [3:0] PULSE_LEN        = 4'(PULSE_CYCLES);
endpackage

// >>> rtc_divider_chain.sv
// clock divider chain for the time-keeping source clock
`timescale 1ns/100ps
module rtc_divider_chain (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // control
    input  wire logic halt_in,
    input  wire logic osc_tick_in,
    // output
    output logic      sec_tick_out
);
    import rtc_flags_pkg::*;

    logic [DIV_WIDTH-1:0] div_q;   // divider flip-flops
    logic [DIV_WIDTH-1:0] div_d;
    logic                 tick_q;  // one-second tick
    logic                 tick_d;

    // next divider count and tick
    always_comb begin
        div_d  = div_q;
        tick_d = 1'b0;
        if (osc_tick_in) begin
            div_d  = div_q + DIV_WIDTH'(1);
            tick_d = &div_q;
        end
    end

    // halt clears the chain asynchronously
    always_ff @(posedge clk_in or posedge rst_in or posedge halt_in) begin
        if (rst_in || halt_in) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    assign sec_tick_out = tick_q;
endmodule

// >>> rtc_control_status_flags.sv
// control and status registers, flags and interrupt of the rtc
`timescale 1ns/100ps
module rtc_control_status_flags (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // register port from serial engine
    input  wire logic       reg_wr_in,
    input  wire logic [3:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    // event inputs
    input  wire logic       osc_tick_in,
    input  wire logic       alarm_match_in,
    input  wire logic       timer_done_in,
    input  wire logic       override_req_in,
    // clock, test and override outputs
    output logic            square_wave_output,
    output logic            sec_tick_out,
    output logic            external_clock_test_mode,
    output logic            override_en_out,
    // open-drain interrupt, low active
    output logic            irq_n_out,
    output logic            irq_oe_out
);
    import rtc_flags_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic       reset_override_test_bit_q;  // override test
    logic       reset_override_test_bit_d;
    logic       div_halt_q;                 // divider halt
    logic       div_halt_d;
    logic       external_clock_test_bit_q;  // external clock test
    logic       external_clock_test_bit_d;
    logic       timer_irq_enable_q;         // timer enable
    logic       timer_irq_enable_d;
    logic       alarm_irq_enable_q;         // alarm enable
    logic       alarm_irq_enable_d;
    logic       timer_flag_q;               // sticky timer flag
    logic       timer_flag_d;
    logic       alarm_flag_q;               // sticky alarm flag
    logic       alarm_flag_d;
    logic       timer_irq_mode_bit_q;       // 0 level, 1 pulse
    logic       timer_irq_mode_bit_d;
    logic [3:0] pulse_cnt_q;                // pulse width counter
    logic [3:0] pulse_cnt_d;
    logic [7:0] rdata_q;                    // read data
    logic [7:0] rdata_d;
    logic       irq_q;                      // interrupt active
    logic       irq_d;
    logic       sq_q;                       // square wave
    logic       sq_d;
    logic       ovr_q;                      // override enable
    logic       ovr_d;
    logic       wr_one;                     // write to control_status_one
    logic       wr_two;                     // write to control_status_two
    logic [7:0] cs_one_view;                // read image of first register
    logic [7:0] cs_two_view;                // read image of second register
    logic       sec_tick;                   // divider tick, already registered

    // write strobes per register
    assign wr_one = reg_wr_in && (reg_addr_in == CS_ONE_ADDR);
    assign wr_two = reg_wr_in && (reg_addr_in == CS_TWO_ADDR);

    ////////////////////////////////////////////////////////////////////////
    // register views
    always_comb begin
        cs_one_view               = 8'h00;
        cs_one_view[EXTERNAL_CLOCK_TEST_MODE_POS]  = external_clock_test_bit_q;
        cs_one_view[DIV_HALT_POS] = div_halt_q;
        cs_one_view[OVR_TEST_POS] = reset_override_test_bit_q;
        cs_two_view               = 8'h00;
        cs_two_view[IRQ_MODE_POS] = timer_irq_mode_bit_q;
        cs_two_view[AF_POS]       = alarm_flag_q;
        cs_two_view[TF_POS]       = timer_flag_q;
        cs_two_view[AIE_POS]      = alarm_irq_enable_q;
        cs_two_view[TIE_POS]      = timer_irq_enable_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // next register values
    always_comb begin
        reset_override_test_bit_d = reset_override_test_bit_q;
        div_halt_d                = div_halt_q;
        external_clock_test_bit_d = external_clock_test_bit_q;
        timer_irq_enable_d        = timer_irq_enable_q;
        alarm_irq_enable_d        = alarm_irq_enable_q;
        timer_irq_mode_bit_d      = timer_irq_mode_bit_q;
        timer_flag_d              = timer_flag_q;
        alarm_flag_d              = alarm_flag_q;
        // control_status_one write
        if (wr_one) begin
            reset_override_test_bit_d = reg_wdata_in[OVR_TEST_POS];
            div_halt_d                = reg_wdata_in[DIV_HALT_POS];
            external_clock_test_bit_d = reg_wdata_in[EXTERNAL_CLOCK_TEST_MODE_POS];
        end
        // control_status_two write, flags ANDed
        if (wr_two) begin
            timer_irq_enable_d   = reg_wdata_in[TIE_POS];
            alarm_irq_enable_d   = reg_wdata_in[AIE_POS];
            timer_irq_mode_bit_d = reg_wdata_in[IRQ_MODE_POS];
            timer_flag_d         = timer_flag_q & reg_wdata_in[TF_POS];
            alarm_flag_d         = alarm_flag_q & reg_wdata_in[AF_POS];
        end
        // events set flags, set beats clear; no self clear
        if (timer_done_in) begin
            timer_flag_d = 1'b1;
        end
        if (alarm_match_in) begin
            alarm_flag_d = 1'b1;
        end
        // read data mux
        unique case (reg_addr_in)
            CS_ONE_ADDR: rdata_d = cs_one_view;
            CS_TWO_ADDR: rdata_d = cs_two_view;
            default:     rdata_d = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt and override next values
    always_comb begin
        pulse_cnt_d = pulse_cnt_q;
        // pulse mode: a fixed pulse per countdown end
        if (timer_done_in) begin
            pulse_cnt_d = PULSE_LEN;
        end else if (pulse_cnt_q != 4'h0) begin
            pulse_cnt_d = pulse_cnt_q - 4'h1;
        end
        irq_d = 1'b0;
        if (timer_irq_enable_q) begin
            if (timer_irq_mode_bit_q) begin
                irq_d = (pulse_cnt_q != 4'h0);
            end else begin
                irq_d = timer_flag_q;
            end
        end
        if (alarm_irq_enable_q && alarm_flag_q) begin
            irq_d = 1'b1;
        end
        // override only when test bit set
        ovr_d = reset_override_test_bit_q && override_req_in;
        // square wave toggles from oscillator regardless of halt
        sq_d = osc_tick_in ? ~sq_q : sq_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reset_override_test_bit_q <= CS_ONE_RESET[OVR_TEST_POS];
            div_halt_q                <= CS_ONE_RESET[DIV_HALT_POS];
            external_clock_test_bit_q <= CS_ONE_RESET[EXTERNAL_CLOCK_TEST_MODE_POS];
            timer_irq_enable_q        <= CS_TWO_RESET[TIE_POS];
            alarm_irq_enable_q        <= CS_TWO_RESET[AIE_POS];
            timer_flag_q              <= CS_TWO_RESET[TF_POS];
            alarm_flag_q              <= CS_TWO_RESET[AF_POS];
            timer_irq_mode_bit_q      <= CS_TWO_RESET[IRQ_MODE_POS];
            pulse_cnt_q               <= 4'h0;
            rdata_q                   <= 8'h00;
            irq_q                     <= 1'b0;
            sq_q                      <= 1'b0;
            ovr_q                     <= 1'b0;
        end else begin
            reset_override_test_bit_q <= reset_override_test_bit_d;
            div_halt_q                <= div_halt_d;
            external_clock_test_bit_q <= external_clock_test_bit_d;
            timer_irq_enable_q        <= timer_irq_enable_d;
            alarm_irq_enable_q        <= alarm_irq_enable_d;
            timer_flag_q              <= timer_flag_d;
            alarm_flag_q              <= alarm_flag_d;
            timer_irq_mode_bit_q      <= timer_irq_mode_bit_d;
            pulse_cnt_q               <= pulse_cnt_d;
            rdata_q                   <= rdata_d;
            irq_q                     <= irq_d;
            sq_q                      <= sq_d;
            ovr_q                     <= ovr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // divider chain, cleared while halted
    rtc_divider_chain u_div (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .halt_in      (div_halt_q),
        .osc_tick_in  (osc_tick_in),
        .sec_tick_out (sec_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops except irq_n_out, which is tied low
    assign reg_rdata_out            = rdata_q;
    assign sec_tick_out             = sec_tick;
    assign square_wave_output       = sq_q;
    assign external_clock_test_mode = external_clock_test_bit_q;
    assign override_en_out          = ovr_q;
    assign irq_n_out                = 1'b0;  // open drain only pulls low
    assign irq_oe_out               = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    // write that clears the timer flag with no competing countdown end
    sequence s_clear_tf;
        wr_two && !reg_wdata_in[TF_POS] && !timer_done_in;
    endsequence
    // write that clears the alarm flag with no competing match
    sequence s_clear_af;
        wr_two && !reg_wdata_in[AF_POS] && !alarm_match_in;
    endsequence
    // countdown end while the pulsed timer interrupt is enabled
    sequence s_pulse_start;
        timer_done_in && timer_irq_enable_q && timer_irq_mode_bit_q && !wr_two;
    endsequence
    // pulse mode with no pulse left and no alarm interrupt pending
    sequence s_pulse_idle;
        pulse_cnt_q == 4'h0 && timer_irq_mode_bit_q && !(alarm_flag_q && alarm_irq_enable_q);
    endsequence

    a_tf_set_event: assert property (@(posedge clk_in) disable iff (rst_in)
        timer_done_in |=> timer_flag_q)
        else $error("timer flag not set");
    a_af_set_event: assert property (@(posedge clk_in) disable iff (rst_in)
        alarm_match_in |=> alarm_flag_q)
        else $error("alarm flag not set");
    a_tf_hold_value: assert property (@(posedge clk_in) disable iff (rst_in)
        timer_flag_q && !wr_two |=> timer_flag_q)
        else $error("timer flag cleared itself");
    a_af_and_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        s_clear_af |=> !alarm_flag_q)
        else $error("alarm flag not cleared by write 0");
    a_tf_and_keep: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_two && reg_wdata_in[TF_POS] && timer_flag_q |=> timer_flag_q)
        else $error("timer flag lost on write 1");
    a_alarm_irq_gate: assert property (@(posedge clk_in) disable iff (rst_in)
        alarm_flag_q && alarm_irq_enable_q |=> irq_oe_out)
        else $error("alarm interrupt missing");
    a_tie_blocks_irq: assert property (@(posedge clk_in) disable iff (rst_in)
        !timer_irq_enable_q && !(alarm_flag_q && alarm_irq_enable_q) |=> !irq_oe_out)
        else $error("interrupt without enabled source");
    a_level_irq_drop: assert property (@(posedge clk_in) disable iff (rst_in)
        s_clear_tf ##1 (!timer_irq_mode_bit_q && !alarm_irq_enable_q) |=> !irq_oe_out)
        else $error("level interrupt stuck after clear");
    a_pulse_irq_len: assert property (@(posedge clk_in) disable iff (rst_in)
        s_pulse_start |=> ##1 irq_oe_out[*8])
        else $error("timer pulse too short");
    a_override_gate: assert property (@(posedge clk_in) disable iff (rst_in)
        !reset_override_test_bit_q |=> !override_en_out)
        else $error("override enabled with test bit 0");

    // alarm flag hold, timer flag clear and alarm flag keep by AND write
    a_af_hold_value: assert property (@(posedge clk_in) disable iff (rst_in)
        alarm_flag_q && !wr_two |=> alarm_flag_q)
        else $error("alarm flag cleared itself");
    a_tf_and_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        s_clear_tf |=> !timer_flag_q)
        else $error("timer flag not cleared by write 0");
    a_af_and_keep: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_two && reg_wdata_in[AF_POS] && alarm_flag_q |=> alarm_flag_q)
        else $error("alarm flag lost on write 1");

    // timer interrupt in level and pulse mode
    a_level_irq_follow: assert property (@(posedge clk_in) disable iff (rst_in)
        timer_flag_q && timer_irq_enable_q && !timer_irq_mode_bit_q |=> irq_oe_out)
        else $error("level interrupt missing");
    a_pulse_irq_end: assert property (@(posedge clk_in) disable iff (rst_in)
        s_pulse_idle |=> !irq_oe_out)
        else $error("timer pulse too long");

    // override, halt and square wave
    a_override_allow: assert property (@(posedge clk_in) disable iff (rst_in)
        reset_override_test_bit_q && override_req_in |=> override_en_out)
        else $error("override not enabled with test bit 1");
    a_halt_write: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_one && reg_wdata_in[DIV_HALT_POS] |=> div_halt_q)
        else $error("halt bit not taken");
    a_halt_no_tick: assert property (@(posedge clk_in) disable iff (rst_in)
        div_halt_q |-> !sec_tick_out)
        else $error("second tick while halted");
    a_run_write: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_one && !reg_wdata_in[DIV_HALT_POS] |=> !div_halt_q)
        else $error("halt bit not released");
    a_square_runs: assert property (@(posedge clk_in) disable iff (rst_in)
        osc_tick_in |=> square_wave_output != $past(square_wave_output))
        else $error("square wave missed an oscillator tick");
endmodule

// >>> rtc_host_model.sv
// host model driving the register port of the rtc flag block
`timescale 1ns/100ps
module rtc_host_model (
    // clock
    input  wire logic       clk_in,
    // register port toward the block
    output logic            reg_wr_out,
    output logic      [3:0] reg_addr_out,
    output logic      [7:0] reg_wdata_out,
    input  wire logic [7:0] reg_rdata_in
);
    // idle bus from time zero
    initial begin
        reg_wr_out    = 1'b0;
        reg_addr_out  = 4'hF;
        reg_wdata_out = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one-cycle write strobe, data released to its inverse afterwards
    task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        reg_wr_out    = 1'b1;
        reg_addr_out  = addr;
        reg_wdata_out = data;
        @(negedge clk_in);
        reg_wr_out    = 1'b0;
        reg_wdata_out = ~data;
    endtask
    // address first, data one edge later; flags are read to find the source
    task automatic read_reg(input logic [3:0] addr, output logic [7:0] data);
        @(negedge clk_in);
        reg_addr_out = addr;
        @(negedge clk_in);
        data = reg_rdata_in;
    endtask
endmodule

// >>> rtc_control_status_flags_test.sv
// self-checking testbench of the rtc control and status flag block
`timescale 1ns/100ps
module rtc_control_status_flags_test;
    import rtc_flags_pkg::*;
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       reg_wr, alarm_match_in = 1'b0, timer_done_in = 1'b0;
    logic       osc_tick_in = 1'b1, override_req_in = 1'b0;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd;
    logic       square_wave_output, sec_tick_out, external_clock_test_mode;
    logic       override_en_out, irq_n_out, irq_oe_out;
    int         n_fail = 0;
    int         checks = 0;
    // 40 MHz clock
    always #12.5 clk_in = ~clk_in;
    // oscillator tick every other cycle, changed at the falling edge
    always @(negedge clk_in) osc_tick_in <= ~osc_tick_in;
    rtc_control_status_flags u_rtc_control_status_flags (.clk_in(clk_in), .rst_in(rst_in),
        .reg_wr_in(reg_wr), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(reg_rdata), .osc_tick_in(osc_tick_in), .alarm_match_in(alarm_match_in),
        .timer_done_in(timer_done_in), .override_req_in(override_req_in),
        .square_wave_output(square_wave_output), .sec_tick_out(sec_tick_out),
        .external_clock_test_mode(external_clock_test_mode),
        .override_en_out(override_en_out), .irq_n_out(irq_n_out), .irq_oe_out(irq_oe_out));
    rtc_host_model u_rtc_host_model (.clk_in(clk_in), .reg_wr_out(reg_wr),
        .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata));
    ////////////////////////////////////////////////////////////////////////////////
    // one comparison, counted
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask
    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // single-cycle event pulses
    task automatic pulse_timer();
        @(negedge clk_in) timer_done_in = 1'b1;
        @(negedge clk_in) timer_done_in = 1'b0;
    endtask
    task automatic pulse_alarm();
        @(negedge clk_in) alarm_match_in = 1'b1;
        @(negedge clk_in) alarm_match_in = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // reset values of both registers and the idle interrupt
    task automatic t_reset();
        u_rtc_host_model.read_reg(CS_ONE_ADDR, rd);
        chk("cs_one reset", CS_ONE_RESET, rd);
        u_rtc_host_model.read_reg(CS_TWO_ADDR, rd);
        chk("cs_two reset", CS_TWO_RESET, rd);
        chk("irq idle", 8'h00, {7'h00, irq_oe_out});
    endtask
    // override gating, unused bits and an unmapped address
    task automatic t_ctrl_one();
        override_req_in = 1'b1;
        u_rtc_host_model.write_reg(CS_ONE_ADDR, 8'h00);
        u_rtc_host_model.read_reg(CS_ONE_ADDR, rd);
        chk("override off", 8'h00, {7'h00, override_en_out});
        u_rtc_host_model.write_reg(CS_ONE_ADDR, 8'hFF);
        u_rtc_host_model.write_reg(4'h5, 8'h00);
        u_rtc_host_model.read_reg(CS_ONE_ADDR, rd);
        chk("cs_one bits", 8'hA8, rd);
        chk("override on", 8'h01, {7'h00, override_en_out});
        chk("ext clock", 8'h01, {7'h00, external_clock_test_mode});
        u_rtc_host_model.read_reg(4'h5, rd);
        chk("unmapped", 8'h00, rd);
        u_rtc_host_model.write_reg(CS_ONE_ADDR, 8'h08);
        override_req_in = 1'b0;
    endtask
    // level timer interrupt held until the flag is cleared
    task automatic t_timer_level();
        u_rtc_host_model.write_reg(CS_TWO_ADDR, 8'h01);
        pulse_timer();
        repeat (20) @(negedge clk_in);
        chk("irq level", 8'h01, {7'h00, irq_oe_out});
        chk("irq pin", 8'h00, {7'h00, irq_n_out});
        u_rtc_host_model.read_reg(CS_TWO_ADDR, rd);
        chk("tf held", 8'h05, rd);
        u_rtc_host_model.write_reg(CS_TWO_ADDR, 8'h01);
        u_rtc_host_model.read_reg(CS_TWO_ADDR, rd);
        chk("tf cleared", 8'h01, rd);
        chk("irq dropped", 8'h00, {7'h00, irq_oe_out});
    endtask
    // both flags, disabled then enabled, cleared one at a time
    task automatic t_and_clear();
        u_rtc_host_model.write_reg(CS_TWO_ADDR, 8'h00);
        pulse_timer();
        pulse_alarm();
        u_rtc_host_model.read_reg(CS_TWO_ADDR, rd);
        chk("both flags", 8'h0C, rd);
        chk("irq masked", 8'h00, {7'h00, irq_oe_out});
        u_rtc_host_model.write_reg(CS_TWO_ADDR, 8'h0B);
        u_rtc_host_model.read_reg(CS_TWO_ADDR, rd);
        chk("af kept", 8'h0B, rd);
        chk("irq alarm", 8'h01, {7'h00, irq_oe_out});
        u_rtc_host_model.write_reg(CS_TWO_ADDR, 8'h03);
        u_rtc_host_model.read_reg(CS_TWO_ADDR, rd);
        chk("af cleared", 8'h03, rd);
        chk("irq none", 8'h00, {7'h00, irq_oe_out});
    endtask
    // pulsed timer interrupt of fixed length
    task automatic t_pulse();
        int n;
        n = 0;
        u_rtc_host_model.write_reg(CS_TWO_ADDR, 8'h11);
        pulse_timer();
        repeat (30) begin
            @(negedge clk_in);
            if (irq_oe_out === 1'b1) n++;
        end
        chk("pulse cycles", 8'(PULSE_CYCLES), 8'(n));
        u_rtc_host_model.write_reg(CS_TWO_ADDR, 8'h00);
    endtask
    // halt clears the divider, square wave keeps running
    task automatic t_halt();
        int n;
        int tg;
        logic sw;
        n = 0;
        tg = 0;
        u_rtc_host_model.write_reg(CS_ONE_ADDR, 8'h28);
        sw = square_wave_output;
        repeat (100) begin
            @(negedge clk_in);
            if (square_wave_output !== sw) tg++;
            if (sec_tick_out === 1'b1) n++;
            sw = square_wave_output;
        end
        chk("halted ticks", 8'h00, 8'(n));
        chk("square toggles", 8'h32, 8'(tg));
        u_rtc_host_model.write_reg(CS_ONE_ADDR, 8'h08);
        n = 0;
        // bounded wait: a missing tick fails the check below
        while (sec_tick_out !== 1'b1 && n < 66000) begin
            @(negedge clk_in);
            n++;
        end
        chk("tick restarted", 8'h01, 8'(n >= 65000 && n < 66000));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (16) @(negedge clk_in);
        rst_in = 1'b0;
        t_reset();
        t_ctrl_one();
        t_timer_level();
        t_and_clear();
        t_pulse();
        t_halt();
        end_of_test();
    end
endmodule
